// [rtl/tfr_regs.svh]
// Command codes, field positions, reset values and retry codes of the temperature supervisor
`ifndef TFR_REGS_SVH
`define TFR_REGS_SVH
`define TFR_CMD_OT_FAULT_THR   8'h4f
`define TFR_CMD_OT_ACTION      8'h50
`define TFR_CMD_OT_WARN_THR    8'h51
`define TFR_CMD_UT_WARN_THR    8'h52
`define TFR_CMD_TIME_UNIT      8'hd2
`define TFR_RESP_HI            7
`define TFR_RESP_LO            6
`define TFR_RETRY_HI           5
`define TFR_RETRY_LO           3
`define TFR_DELAY_HI           2
`define TFR_DELAY_LO           0
`define TFR_RST_OT_FAULT_THR   16'h0000
`define TFR_RST_OT_ACTION      8'h00
`define TFR_RST_OT_WARN_THR    16'h0000
`define TFR_RST_UT_WARN_THR    16'h0000
`define TFR_RST_TIME_UNIT      16'h0001
`define TFR_RETRY_NONE         3'h0
`define TFR_RETRY_FOREVER      3'h7
`endif

// [rtl/tfr_pkg.sv]
// Types shared by the temperature fault response block
package tfr_pkg;
  typedef enum logic [1:0] {
    TFR_RESP_IGNORE  = 2'b00,
    TFR_RESP_DELAYED = 2'b01,
    TFR_RESP_RETRY   = 2'b10,
    TFR_RESP_RESUME  = 2'b11
  } tfr_resp_type;

  typedef enum logic [2:0] {
    TFR_ST_RUN     = 3'b000,
    TFR_ST_GRACE   = 3'b001,
    TFR_ST_WAIT    = 3'b010,
    TFR_ST_RESTART = 3'b011,
    TFR_ST_LATCHED = 3'b100,
    TFR_ST_HOLD    = 3'b101
  } tfr_state_type;
endpackage

// [rtl/tfr_temperature_fault_response.sv]
// Over- and under-temperature supervision with programmable fault response
`timescale 1ns/1ps
`include "tfr_regs.svh"
module tfr_temperature_fault_response (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_wr_en,
  input  wire logic                 i_rd_en,
  input  wire logic [7:0]           i_cmd,
  input  wire logic [15:0]          i_wr_data,
  input  wire logic signed [15:0]   i_temperature,
  input  wire logic                 i_temp_valid,
  input  wire logic                 i_output_on_cmd,
  input  wire logic                 i_fault_clear,
  input  wire logic                 i_other_fault,
  output logic [15:0]               o_rd_data,
  output logic                      o_rd_valid,
  output logic                      o_output_enable,
  output logic                      o_overtemp_fault,
  output logic                      o_overtemp_warning,
  output logic                      o_undertemp_warning,
  output logic                      o_fault_latched
);
  import tfr_pkg::*;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [15:0] overtemp_fault_threshold;
  logic [7:0]  overtemp_fault_action;
  logic [15:0] overtemp_warning_threshold;
  logic [15:0] undertemp_warning_threshold;
  logic [15:0] delay_time_unit;
  logic [15:0] next_overtemp_fault_threshold;
  logic [7:0]  next_overtemp_fault_action;
  logic [15:0] next_overtemp_warning_threshold;
  logic [15:0] next_undertemp_warning_threshold;
  logic [15:0] next_delay_time_unit;
  logic [15:0] next_rd_data;
  logic        next_rd_valid;

  always_comb begin
    next_overtemp_fault_threshold    = overtemp_fault_threshold;
    next_overtemp_fault_action       = overtemp_fault_action;
    next_overtemp_warning_threshold  = overtemp_warning_threshold;
    next_undertemp_warning_threshold = undertemp_warning_threshold;
    next_delay_time_unit             = delay_time_unit;
    if (i_wr_en) begin
      unique case (i_cmd)
        `TFR_CMD_OT_FAULT_THR: next_overtemp_fault_threshold = i_wr_data;
        `TFR_CMD_OT_ACTION:    next_overtemp_fault_action = i_wr_data[7:0];
        `TFR_CMD_OT_WARN_THR:  next_overtemp_warning_threshold = i_wr_data;
        `TFR_CMD_UT_WARN_THR:  next_undertemp_warning_threshold = i_wr_data;
        `TFR_CMD_TIME_UNIT:    next_delay_time_unit = i_wr_data;
        default: begin
        end
      endcase
    end
    next_rd_valid = i_rd_en;
    next_rd_data  = 16'h0000;
    if (i_rd_en) begin
      unique case (i_cmd)
        `TFR_CMD_OT_FAULT_THR: next_rd_data = overtemp_fault_threshold;
        `TFR_CMD_OT_ACTION:    next_rd_data = {8'h00, overtemp_fault_action};
        `TFR_CMD_OT_WARN_THR:  next_rd_data = overtemp_warning_threshold;
        `TFR_CMD_UT_WARN_THR:  next_rd_data = undertemp_warning_threshold;
        `TFR_CMD_TIME_UNIT:    next_rd_data = delay_time_unit;
        default:               next_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      overtemp_fault_threshold    <= `TFR_RST_OT_FAULT_THR;
      overtemp_fault_action       <= `TFR_RST_OT_ACTION;
      overtemp_warning_threshold  <= `TFR_RST_OT_WARN_THR;
      undertemp_warning_threshold <= `TFR_RST_UT_WARN_THR;
      delay_time_unit             <= `TFR_RST_TIME_UNIT;
      o_rd_data                   <= 16'h0000;
      o_rd_valid                  <= 1'b0;
    end else begin
      overtemp_fault_threshold    <= next_overtemp_fault_threshold;
      overtemp_fault_action       <= next_overtemp_fault_action;
      overtemp_warning_threshold  <= next_overtemp_warning_threshold;
      undertemp_warning_threshold <= next_undertemp_warning_threshold;
      delay_time_unit             <= next_delay_time_unit;
      o_rd_data                   <= next_rd_data;
      o_rd_valid                  <= next_rd_valid;
    end
  end

  // ----------------------------------------------------------------
  // Threshold comparison
  // ----------------------------------------------------------------
  logic next_ot_fault;
  logic next_ot_warn;
  logic next_ut_warn;

  // Thresholds are compared as signed raw readings in the same format as the sensor
  always_comb begin
    next_ot_fault = o_overtemp_fault;
    next_ot_warn  = o_overtemp_warning;
    next_ut_warn  = o_undertemp_warning;
    if (i_temp_valid) begin
      next_ot_fault = i_temperature >= $signed(overtemp_fault_threshold);
      next_ot_warn  = i_temperature >= $signed(overtemp_warning_threshold);
      next_ut_warn  = i_temperature <= $signed(undertemp_warning_threshold);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_overtemp_fault    <= 1'b0;
      o_overtemp_warning  <= 1'b0;
      o_undertemp_warning <= 1'b0;
    end else begin
      o_overtemp_fault    <= next_ot_fault;
      o_overtemp_warning  <= next_ot_warn;
      o_undertemp_warning <= next_ot_warn ? 1'b0 : next_ut_warn;
    end
  end

  // ----------------------------------------------------------------
  // Fault response sequencer
  // ----------------------------------------------------------------
  tfr_state_type state;
  tfr_state_type next_state;
  logic [22:0]   delay_cnt;
  logic [22:0]   next_delay_cnt;
  logic [2:0]    tries;
  logic [2:0]    next_tries;
  logic          next_output_enable;
  logic          next_fault_latched;
  tfr_resp_type  resp;
  logic [2:0]    retry_set;
  logic [22:0]   delay_cycles;
  logic [22:0]   delay_load;

  assign resp      = tfr_resp_type'(overtemp_fault_action[`TFR_RESP_HI:`TFR_RESP_LO]);
  assign retry_set = overtemp_fault_action[`TFR_RETRY_HI:`TFR_RETRY_LO];
  // Delay code n gives 2**n units of the configured size
  assign delay_cycles = 23'(delay_time_unit) <<
                        overtemp_fault_action[`TFR_DELAY_HI:`TFR_DELAY_LO];
  // Counter acts on reaching zero, so one less is loaded to keep the span exact
  assign delay_load = (delay_cycles != 23'h000000) ? delay_cycles - 23'h000001
                                                   : 23'h000000;

  always_comb begin
    next_state         = state;
    next_delay_cnt     = (delay_cnt != 23'h000000) ? delay_cnt - 23'h000001 : delay_cnt;
    next_tries         = tries;
    next_output_enable = i_output_on_cmd;
    next_fault_latched = 1'b0;
    unique case (state)
      TFR_ST_RUN: begin
        if (o_overtemp_fault) begin
          next_tries = 3'h0;
          unique case (resp)
            TFR_RESP_IGNORE: next_state = TFR_ST_RUN;
            TFR_RESP_DELAYED: begin
              next_state     = TFR_ST_GRACE;
              next_delay_cnt = delay_load;
            end
            TFR_RESP_RETRY: begin
              next_output_enable = 1'b0;
              next_delay_cnt     = delay_load;
              next_state = (retry_set == `TFR_RETRY_NONE) ? TFR_ST_LATCHED : TFR_ST_WAIT;
            end
            TFR_RESP_RESUME: begin
              next_output_enable = 1'b0;
              next_state         = TFR_ST_HOLD;
            end
          endcase
        end
      end
      TFR_ST_GRACE: begin
        if (!o_overtemp_fault) begin
          next_state = TFR_ST_RUN;
        end else if (delay_cnt == 23'h000000) begin
          next_output_enable = 1'b0;
          next_delay_cnt     = delay_load;
          next_state = (retry_set == `TFR_RETRY_NONE) ? TFR_ST_LATCHED : TFR_ST_WAIT;
        end
      end
      TFR_ST_WAIT: begin
        next_output_enable = 1'b0;
        if (!i_output_on_cmd || i_other_fault) begin
          next_state = TFR_ST_LATCHED;
        end else if (delay_cnt == 23'h000000) begin
          // Spacing counts from one attempt start to the next
          next_delay_cnt     = delay_load;
          next_output_enable = 1'b1;
          if (retry_set != `TFR_RETRY_FOREVER) begin
            next_tries = tries + 3'h1;
          end
          next_state = TFR_ST_RESTART;
        end
      end
      TFR_ST_RESTART: begin
        if (o_overtemp_fault || !i_output_on_cmd || i_other_fault) begin
          next_output_enable = 1'b0;
          if (retry_set != `TFR_RETRY_FOREVER && tries >= retry_set) begin
            next_state = TFR_ST_LATCHED;
          end else if (!i_output_on_cmd || i_other_fault) begin
            next_state = TFR_ST_LATCHED;
          end else begin
            next_state = TFR_ST_WAIT;
          end
        end else if (delay_cnt == 23'h000000) begin
          next_state = TFR_ST_RUN;
        end
      end
      TFR_ST_LATCHED: begin
        next_output_enable = 1'b0;
        next_fault_latched = 1'b1;
        if (i_fault_clear) begin
          next_state         = TFR_ST_RUN;
          next_fault_latched = 1'b0;
        end
      end
      TFR_ST_HOLD: begin
        next_output_enable = 1'b0;
        if (!o_overtemp_fault) begin
          next_output_enable = i_output_on_cmd;
          next_state         = TFR_ST_RUN;
        end
      end
      default: begin
        next_output_enable = 1'b0;
        next_state         = TFR_ST_LATCHED;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state           <= TFR_ST_RUN;
      delay_cnt       <= 23'h000000;
      tries           <= 3'h0;
      o_output_enable <= 1'b0;
      o_fault_latched <= 1'b0;
    end else begin
      state           <= next_state;
      delay_cnt       <= next_delay_cnt;
      tries           <= next_tries;
      o_output_enable <= next_output_enable;
      o_fault_latched <= next_fault_latched;
    end
  end
endmodule

// [testbench/tfr_properties.sv]
// Port checker of the temperature fault response block
`timescale 1ns/1ps
module tfr_properties (
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic               i_wr_en,
  input wire logic               i_rd_en,
  input wire logic [7:0]         i_cmd,
  input wire logic [15:0]        i_wr_data,
  input wire logic signed [15:0] i_temperature,
  input wire logic               i_temp_valid,
  input wire logic               i_fault_clear,
  input wire logic [15:0]        o_rd_data,
  input wire logic               o_rd_valid,
  input wire logic               o_output_enable,
  input wire logic               o_overtemp_fault,
  input wire logic               o_overtemp_warning,
  input wire logic               o_fault_latched
);
  logic        [7:0]  act;
  logic signed [15:0] fthr;
  logic signed [15:0] wthr;
  // Shadow copies of the programmed action and the overtemperature fault and warning thresholds
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act <= 8'h00;
      fthr <= 16'sh0000;
      wthr <= 16'sh0000;
    end else if (i_wr_en) begin
      if (i_cmd == 8'h50) act <= i_wr_data[7:0];
      if (i_cmd == 8'h4f) fthr <= i_wr_data;
      if (i_cmd == 8'h51) wthr <= i_wr_data;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_rd_valid_pulse: assert property (i_rd_en |=> o_rd_valid)
    else $error("read strobe not answered");
  a_rd_idle_zero: assert property (!i_rd_en |=> !o_rd_valid && o_rd_data == 16'h0000)
    else $error("read data not idle");
  a_fault_compare: assert property (i_temp_valid |=>
    o_overtemp_fault == ($past(i_temperature) >= $past(fthr)))
    else $error("fault flag wrong");
  a_warn_compare: assert property (i_temp_valid |=>
    o_overtemp_warning == ($past(i_temperature) >= $past(wthr)))
    else $error("warning flag wrong");
  a_resume_off: assert property (act[7:6] == 2'b11 && o_overtemp_fault |=> !o_output_enable)
    else $error("output on during fault");
  a_disable_now: assert property (act[7:6] == 2'b10 && $rose(o_overtemp_fault)
    |=> !o_output_enable)
    else $error("output not disabled");
  a_delay_grace: assert property (act[7:6] == 2'b01 && $rose(o_overtemp_fault) && o_output_enable
    |=> o_output_enable)
    else $error("output dropped early");
  a_latched_off: assert property (o_fault_latched |-> !o_output_enable)
    else $error("output on while latched");
  a_clear_release: assert property (o_fault_latched && i_fault_clear |=> !o_fault_latched)
    else $error("latch not released");
  c_latched: cover property (o_fault_latched);
  c_restart: cover property (act[7:6] == 2'b10 && $rose(o_output_enable));
  c_read: cover property (o_rd_valid);
endmodule
bind tfr_temperature_fault_response tfr_properties tfr_properties_inst (.i_clk(i_clk),
  .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_cmd(i_cmd), .i_wr_data(i_wr_data),
  .i_temperature(i_temperature), .i_temp_valid(i_temp_valid), .i_fault_clear(i_fault_clear),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_output_enable(o_output_enable),
  .o_overtemp_fault(o_overtemp_fault), .o_overtemp_warning(o_overtemp_warning),
  .o_fault_latched(o_fault_latched));

// [testbench/tfr_host_model.sv]
// Host model driving the register port
`timescale 1ns/1ps
module tfr_host_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_valid,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic [7:0]       o_cmd,
  output logic [15:0]      o_wr_data
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_cmd = 8'h00;
    o_wr_data = 16'h0000;
  end
  // Released lines show the inverse so stale values are never reused
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b1;
    o_cmd = cmd;
    o_wr_data = data;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_cmd = ~cmd;
    o_wr_data = ~data;
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output logic valid);
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b1;
    o_cmd = cmd;
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b0;
    o_cmd = ~cmd;
    data = i_rd_data;
    valid = i_rd_valid;
  endtask
endmodule

// [testbench/tfr_temperature_fault_response_tb_top.sv]
// Self-checking bench of the temperature fault response block
`timescale 1ns/1ps
module tfr_temperature_fault_response_tb_top;
  logic i_clk = 1'b0, i_rst = 1'b1, i_temp_valid = 1'b0, i_output_on_cmd = 1'b1;
  logic i_fault_clear = 1'b0, i_other_fault = 1'b0, o_rd_valid, o_output_enable, o_fault_latched;
  logic i_wr_en, i_rd_en, o_overtemp_fault, o_overtemp_warning, o_undertemp_warning;
  logic [7:0] i_cmd;
  logic [15:0] i_wr_data, o_rd_data;
  logic signed [15:0] i_temperature = 16'sh0030;
  int bad_count = 0, checked = 0, n, gap;
  event hung;
  tfr_host_model tfr_host_model_inst (.i_clk(i_clk), .i_rd_data(o_rd_data),
    .i_rd_valid(o_rd_valid), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_cmd(i_cmd),
    .o_wr_data(i_wr_data));
  tfr_temperature_fault_response tfr_temperature_fault_response_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_cmd(i_cmd), .i_wr_data(i_wr_data),
    .i_temperature(i_temperature), .i_temp_valid(i_temp_valid),
    .i_output_on_cmd(i_output_on_cmd), .i_fault_clear(i_fault_clear),
    .i_other_fault(i_other_fault),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_output_enable(o_output_enable),
    .o_overtemp_fault(o_overtemp_fault), .o_overtemp_warning(o_overtemp_warning),
    .o_undertemp_warning(o_undertemp_warning), .o_fault_latched(o_fault_latched));
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    tfr_host_model_inst.rd(cmd, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
  endtask
  task automatic setup(input logic [7:0] act, input logic [15:0] unit);
    i_rst = 1'b1;
    i_temp_valid = 1'b0;
    i_output_on_cmd = 1'b1;
    i_temperature = 16'sh0030;
    tick(5);
    i_rst = 1'b0;
    tfr_host_model_inst.wr(8'h4f, 16'h0050);
    tfr_host_model_inst.wr(8'h51, 16'h0040);
    tfr_host_model_inst.wr(8'h52, 16'h0010);
    tfr_host_model_inst.wr(8'h50, {8'h00, act});
    tfr_host_model_inst.wr(8'hd2, unit);
    i_temp_valid = 1'b1;
    tick(4);
  endtask
  task automatic wait_oe(input logic lvl, input int bound);
    n = 0;
    while (o_output_enable !== lvl) begin
      if (n == bound) begin
        $display("BAD t=%0t got=%h exp=%h", $time, o_output_enable, lvl);
        -> hung;
        wait (0);
      end
      tick(1);
      n++;
    end
  endtask
  // Counts restart rising edges and the shortest spacing between them
  task automatic count_rise(input int cyc);
    int last;
    logic prev;
    n = 0;
    gap = 1000;
    last = 0;
    prev = o_output_enable;
    for (int k = 1; k <= cyc; k++) begin
      tick(1);
      if (o_output_enable === 1'b1 && prev !== 1'b1) begin
        if (n > 0 && k - last < gap) gap = k - last;
        n++;
        last = k;
      end
      prev = o_output_enable;
    end
  endtask
  task automatic t_regs();
    i_rst = 1'b1;
    tick(5);
    i_rst = 1'b0;
    rc(8'h4f, 16'h0000);
    rc(8'h50, 16'h0000);
    setup(8'hc5, 16'h0003);
    rc(8'h4f, 16'h0050);
    rc(8'h50, 16'h00c5);
    rc(8'h51, 16'h0040);
    rc(8'h52, 16'h0010);
    rc(8'hd2, 16'h0003);
    rc(8'h00, 16'h0000);
    i_temperature = 16'sh0045;
    tick(3);
    chk({14'h0000, o_overtemp_warning, o_undertemp_warning}, 16'h0002);
    i_temperature = 16'sh0005;
    tick(3);
    chk({14'h0000, o_overtemp_warning, o_undertemp_warning}, 16'h0001);
  endtask
  task automatic t_ignore();
    setup(8'h00, 16'h0001);
    i_temperature = 16'sh0060;
    tick(20);
    chk({15'h0000, o_overtemp_fault}, 16'h0001);
    chk({15'h0000, o_output_enable}, 16'h0001);
  endtask
  task automatic t_delayed();
    int d;
    for (int j = 0; j < 3; j++) begin
      d = (j == 0) ? 0 : (j == 1) ? 3 : 7;
      setup({5'b01000, 3'(d)}, 16'h0001);
      i_temperature = 16'sh0060;
      tick((1 << d) + 1);
      chk({15'h0000, o_output_enable}, 16'h0001);
      tick(1);
      chk({15'h0000, o_output_enable}, 16'h0000);
    end
  endtask
  task automatic t_resume();
    setup(8'hc0, 16'h0001);
    i_temperature = 16'sh0060;
    tick(3);
    chk({15'h0000, o_output_enable}, 16'h0000);
    i_temperature = 16'sh0030;
    wait_oe(1'b1, 6);
  endtask
  task automatic t_retry(input logic [7:0] act, input int exp);
    setup(act, 16'h0004);
    i_temperature = 16'sh0060;
    count_rise(200);
    chk(16'(n), 16'(exp));
    chk({15'h0000, o_fault_latched}, 16'h0001);
    if (exp > 1) chk(16'(gap), 16'h0004);
    i_temperature = 16'sh0030;
    tick(2);
    i_fault_clear = 1'b1;
    tick(1);
    i_fault_clear = 1'b0;
    wait_oe(1'b1, 6);
  endtask
  task automatic t_forever();
    setup(8'hb8, 16'h0002);
    i_temperature = 16'sh0060;
    count_rise(200);
    chk({15'h0000, n > 7}, 16'h0001);
    chk(16'(gap), 16'h0002);
    i_other_fault = 1'b1;
    tick(4);
    chk({15'h0000, o_fault_latched}, 16'h0001);
    i_other_fault = 1'b0;
    i_fault_clear = 1'b1;
    tick(1);
    i_fault_clear = 1'b0;
    count_rise(20);
    chk({15'h0000, n > 7}, 16'h0001);
    i_output_on_cmd = 1'b0;
    tick(20);
    chk({15'h0000, o_output_enable}, 16'h0000);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    @(hung);
    bad_count++;
    give_verdict();
  end
  initial begin
    t_regs();
    t_ignore();
    t_delayed();
    t_resume();
    t_retry(8'h90, 2);
    t_retry(8'h80, 0);
    t_forever();
    give_verdict();
  end
endmodule
